// ---- sfq_host.sv ----
// host model for the serial pins of the read sequencer
// assumes clk is the system clock; the testbench calls the tasks
`timescale 1ns/1ps

module sfq_host (
    input  wire logic        clk,
    output logic             sck,
    output logic             cs_n,
    output logic      [3:0]  io_in,
    input  wire logic [3:0]  io_out,
    input  wire logic [3:0]  io_oe_n,
    input  wire logic        hold_active
);
    logic        drv_en = 1'b0;
    logic [3:0]  drv_d = 4'h0;
    logic        flt_q = 1'b0;
    logic [3:0]  oe_dum;
    logic [3:0]  oe_dat;
    logic [7:0]  pat;
    logic [63:0] rx;
    logic        hold_seen;

    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
    end

    // a released line toggles, so a stale level never passes for data
    always @(posedge clk)
        flt_q <= ~flt_q;

    always_comb
        for (int i = 0; i < 4; i++)
            io_in[i] = !io_oe_n[i] ? io_out[i] : (drv_en ? drv_d[i] : flt_q);

    // data leads each edge by 3 clk; 9 clk halves keep sck near 7 MHz
    task automatic edge_step(input logic [3:0] d, input logic en);
        @(posedge clk);
        drv_d <= d;
        drv_en <= en;
        repeat (3) @(posedge clk);
        sck <= ~sck;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask : edge_step

    task automatic sdr_clk(input logic [3:0] d, input logic en);
        edge_step(d, en);
        edge_step(d, en);
    endtask : sdr_clk

    task automatic frame_open;
        @(posedge clk);
        cs_n <= 1'b0;
        oe_dum = 4'hF;
        oe_dat = 4'h0;
        rx = '0;
        pat = '0;
        hold_seen = 1'b0;
    endtask : frame_open

    task automatic frame_close;
        if (sck)
            edge_step(4'h0, 1'b0);
        @(posedge clk);
        cs_n <= 1'b1;
        drv_en <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : frame_close

    task automatic short_frame;
        frame_open();
        repeat (4) sdr_clk(4'h0, 1'b1);
        frame_close();
    endtask : short_frame

    task automatic quad_read(input logic op_on, input logic [7:0] op,
        input logic [31:0] a, input int nib, input logic [7:0] md,
        input int nd, input int nb);
        frame_open();
        if (op_on)
            for (int i = 7; i >= 0; i--)
                sdr_clk({3'h0, op[i]}, 1'b1);
        for (int i = nib - 1; i >= 0; i--)
            sdr_clk(a[4*i +: 4], 1'b1);
        sdr_clk(md[7:4], 1'b1);
        edge_step(md[3:0], 1'b1);
        edge_step(md[3:0], 1'b0);
        for (int c = 0; c < nd + 2 * nb - 1; c++)
        begin
            sdr_clk(4'h0, 1'b0);
            if (c < nd - 1)
                oe_dum &= io_oe_n;
            else
            begin
                oe_dat |= io_oe_n;
                rx = {rx[59:0], io_out};
            end
        end
        frame_close();
    endtask : quad_read

    task automatic ddr_read(input logic op_on, input logic [7:0] op,
        input logic [31:0] a, input int nbit, input logic md_on,
        input logic [7:0] md, input int nd, input logic pre, input int nb);
        frame_open();
        if (op_on)
            for (int i = 7; i >= 0; i--)
                sdr_clk({3'h0, op[i]}, 1'b1);
        for (int i = nbit - 1; i >= 0; i--)
            edge_step({3'h0, a[i]}, 1'b1);
        if (md_on)
            for (int i = 7; i >= 0; i--)
                edge_step({3'h0, md[i]}, 1'b1);
        for (int e = 1; e < 2 * nd + 8 * nb; e++)
        begin
            edge_step(4'h0, 1'b0);
            hold_seen |= hold_active;
            if (e < 2 * nd - (pre ? 8 : 0))
                oe_dum &= io_oe_n;
            else if (e < 2 * nd)
                pat = {pat[6:0], io_out[1]};
            else
                rx = {rx[62:0], io_out[1]};
        end
        frame_close();
    endtask : ddr_read
endmodule : sfq_host

// ---- sfq_pkg.sv ----
// constants for the quad i/o and double rate read sequencer
// assumes the sequencer and the testbench are its users; the testbench reads its dummy tables
package sfq_pkg;

    localparam logic [7:0]  SFQ_OPC_QIO        = 8'hEB;
    localparam logic [7:0]  SFQ_OPC_QIO4       = 8'hEC;
    localparam logic [7:0]  SFQ_OPC_DDR        = 8'h0D;
    localparam logic [7:0]  SFQ_OPC_DDR4       = 8'h0E;
    localparam logic [3:0]  SFQ_MODE_CONT      = 4'hA;

    localparam int          SFQ_CFG_QUAD_BIT   = 1;
    localparam int          SFQ_CFG_LC_HI      = 7;
    localparam int          SFQ_CFG_LC_LO      = 6;

    // phase lengths: sdr phases count rising edges, ddr phases count edges
    localparam logic [5:0]  SFQ_OPC_CLKS       = 6'h08;
    localparam logic [5:0]  SFQ_QIO_ADDR3_CLKS = 6'h06;
    localparam logic [5:0]  SFQ_QIO_ADDR4_CLKS = 6'h08;
    localparam logic [5:0]  SFQ_DDR_ADDR3_EDGS = 6'h18;
    localparam logic [5:0]  SFQ_DDR_ADDR4_EDGS = 6'h20;
    localparam logic [5:0]  SFQ_QIO_MODE_CLKS  = 6'h02;
    localparam logic [5:0]  SFQ_DDR_MODE_EDGS  = 6'h08;
    localparam logic [5:0]  SFQ_DLP_EDGS       = 6'h08;
    localparam logic [3:0]  SFQ_SHORT_CLKS     = 4'h8;

    // dummy clocks per latency code; plain defaults, index is the code
    localparam logic [5:0]  SFQ_QIO_DUMMY [4]  = '{6'h04, 6'h04, 6'h05, 6'h01};
    localparam logic [5:0]  SFQ_DDR_DUMMY_B [4] = '{6'h05, 6'h06, 6'h07, 6'h08};
    localparam logic [5:0]  SFQ_DDR_DUMMY_E [4] = '{6'h05, 6'h06, 6'h07, 6'h08};

    localparam logic [31:0] SFQ_ADDR_TOP       = 32'hFFFFFFFF;

    localparam logic        SFQ_SCK_RST        = 1'b0;
    localparam logic        SFQ_CS_RST         = 1'b1;
    localparam logic [3:0]  SFQ_OE_OFF         = 4'hF;
    localparam logic [3:0]  SFQ_OE_SO          = 4'hD;
    localparam logic [3:0]  SFQ_OE_ALL         = 4'h0;

    typedef enum logic [2:0] {
        SFQ_ST_OPC,
        SFQ_ST_ADDR,
        SFQ_ST_MODE,
        SFQ_ST_DUMMY,
        SFQ_ST_DATA,
        SFQ_ST_IGN
    } sfq_state_type;

endpackage : sfq_pkg

// ---- sfq_read_seq.sv ----
// read sequencer for the quad i/o read and the double rate fast read
// assumes sck, cs_n, io_in and hold_n come from pins (synchronised here);
// config inputs and mem_data come from logic on clk; mem_data follows
// mem_addr combinationally in the same cycle
`timescale 1ns/1ps

module sfq_read_seq (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe_n,
    input  wire logic        hold_n,
    output logic             hold_active,
    input  wire logic [7:0]  config_reg_one,
    input  wire logic        extended_address_sel,
    input  wire logic        enhanced_latency_table,
    input  wire logic        data_learning_preamble,
    input  wire logic [7:0]  dlp_pattern,
    output logic      [31:0] mem_addr,
    input  wire logic [7:0]  mem_data,
    output logic             cont_quad,
    output logic             cont_ddr
);

    logic                 sck_m, sck_s, sck_p;
    logic                 cs_m, cs_s, cs_p;
    logic [3:0]           io_m, io_s;
    logic                 hold_m, hold_s;
    sfq_pkg::sfq_state_type state_q;
    logic [5:0]           cnt_q;
    logic                 ddr_q, four_q, nib_q;
    logic [2:0]           bi_q;
    logic [7:0]           opc_q, mode_q;
    logic [31:0]          addr_q;
    logic [3:0]           rcnt_q;
    logic                 valid_q, pend_quad_q, pend_ddr_q;
    logic                 cont_quad_q, cont_ddr_q, hold_active_q;
    logic [3:0]           io_out_q, io_oe_n_q;

    logic                 rise_e, fall_e, cs_rise, cs_fall, u_e, phase_end;
    logic [5:0]           plen_c, dlen_c;
    logic [7:0]           opc_d, mode_d;
    logic [1:0]           lc_c;
    logic                 quad_en, is_qio, is_ddr;
    logic [31:0]          addr_nx;

    // two-flop synchronisers; stage one feeds stage two only
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sck_m  <= sfq_pkg::SFQ_SCK_RST;
            sck_s  <= sfq_pkg::SFQ_SCK_RST;
            sck_p  <= sfq_pkg::SFQ_SCK_RST;
            cs_m   <= sfq_pkg::SFQ_CS_RST;
            cs_s   <= sfq_pkg::SFQ_CS_RST;
            cs_p   <= sfq_pkg::SFQ_CS_RST;
            io_m   <= 4'h0;
            io_s   <= 4'h0;
            hold_m <= 1'b1;
            hold_s <= 1'b1;
        end
        else
        begin
            sck_m  <= sck;
            sck_s  <= sck_m;
            sck_p  <= sck_s;
            cs_m   <= cs_n;
            cs_s   <= cs_m;
            cs_p   <= cs_s;
            io_m   <= io_in;
            io_s   <= io_m;
            hold_m <= hold_n;
            hold_s <= hold_m;
        end
    end

    assign rise_e  = sck_s & ~sck_p & ~cs_s;
    assign fall_e  = ~sck_s & sck_p & ~cs_s;
    assign cs_rise = cs_s & ~cs_p;
    assign cs_fall = ~cs_s & cs_p;

    assign quad_en = config_reg_one[sfq_pkg::SFQ_CFG_QUAD_BIT];
    assign lc_c    = config_reg_one[sfq_pkg::SFQ_CFG_LC_HI:
                                    sfq_pkg::SFQ_CFG_LC_LO];
    assign opc_d   = {opc_q[6:0], io_s[0]};
    assign mode_d  = ddr_q ? {mode_q[6:0], io_s[0]} : {mode_q[3:0], io_s};
    assign is_qio  = (opc_d == sfq_pkg::SFQ_OPC_QIO) ||
                     (opc_d == sfq_pkg::SFQ_OPC_QIO4);
    assign is_ddr  = (opc_d == sfq_pkg::SFQ_OPC_DDR) ||
                     (opc_d == sfq_pkg::SFQ_OPC_DDR4);
    assign addr_nx = (addr_q == sfq_pkg::SFQ_ADDR_TOP) ? 32'h00000000
                                                       : addr_q + 32'h00000001;

    // quad reads use the quad table; ddr reads pick the enhanced or basic table, which hold the same figures
    always_comb
    begin
        if (!ddr_q)
            dlen_c = sfq_pkg::SFQ_QIO_DUMMY[lc_c];
        else if (enhanced_latency_table)
            dlen_c = sfq_pkg::SFQ_DDR_DUMMY_E[lc_c];
        else
            dlen_c = sfq_pkg::SFQ_DDR_DUMMY_B[lc_c];
    end

    always_comb
    begin
        case (state_q)
            sfq_pkg::SFQ_ST_OPC:   plen_c = sfq_pkg::SFQ_OPC_CLKS;
            sfq_pkg::SFQ_ST_ADDR:
                if (ddr_q)
                    plen_c = four_q ? sfq_pkg::SFQ_DDR_ADDR4_EDGS
                                    : sfq_pkg::SFQ_DDR_ADDR3_EDGS;
                else
                    plen_c = four_q ? sfq_pkg::SFQ_QIO_ADDR4_CLKS
                                    : sfq_pkg::SFQ_QIO_ADDR3_CLKS;
            sfq_pkg::SFQ_ST_MODE:
                plen_c = ddr_q ? sfq_pkg::SFQ_DDR_MODE_EDGS
                               : sfq_pkg::SFQ_QIO_MODE_CLKS;
            sfq_pkg::SFQ_ST_DUMMY: plen_c = ddr_q ? {dlen_c[4:0], 1'b0} : dlen_c;
            default:               plen_c = 6'h3F;
        endcase
    end

    // ddr phases start on a rising edge; the fall after the opcode is skipped
    assign u_e = (state_q == sfq_pkg::SFQ_ST_OPC || !ddr_q) ? rise_e
               : (rise_e | (fall_e & (cnt_q != 6'h00)));
    assign phase_end = u_e && (cnt_q == plen_c - 6'h01);

    // command sequencing and the read address
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_q <= sfq_pkg::SFQ_ST_OPC;
            cnt_q   <= 6'h00;
            ddr_q   <= 1'b0;
            four_q  <= 1'b0;
            opc_q   <= 8'h00;
            mode_q  <= 8'h00;
            addr_q  <= 32'h00000000;
            nib_q   <= 1'b0;
            bi_q    <= 3'h0;
        end
        else if (cs_fall)
        begin
            // continuous modes open straight on the address
            state_q <= (cont_quad_q | cont_ddr_q) ? sfq_pkg::SFQ_ST_ADDR
                                                  : sfq_pkg::SFQ_ST_OPC;
            ddr_q   <= cont_ddr_q;
            cnt_q   <= 6'h00;
            addr_q  <= 32'h00000000;
        end
        else if (!cs_s)
        begin
            case (state_q)
                sfq_pkg::SFQ_ST_OPC:
                    if (u_e)
                    begin
                        opc_q <= opc_d;
                        cnt_q <= cnt_q + 6'h01;
                        if (phase_end)
                        begin
                            cnt_q <= 6'h00;
                            ddr_q <= is_ddr;
                            four_q <= extended_address_sel |
                                      (opc_d == sfq_pkg::SFQ_OPC_QIO4) |
                                      (opc_d == sfq_pkg::SFQ_OPC_DDR4);
                            if ((is_qio && quad_en) || is_ddr)
                                state_q <= sfq_pkg::SFQ_ST_ADDR;
                            else
                                state_q <= sfq_pkg::SFQ_ST_IGN;
                        end
                    end
                sfq_pkg::SFQ_ST_ADDR:
                    if (u_e)
                    begin
                        addr_q <= ddr_q ? {addr_q[30:0], io_s[0]}
                                        : {addr_q[27:0], io_s};
                        cnt_q  <= cnt_q + 6'h01;
                        if (phase_end)
                        begin
                            cnt_q <= 6'h00;
                            if (ddr_q && !enhanced_latency_table)
                                state_q <= sfq_pkg::SFQ_ST_DUMMY;
                            else
                                state_q <= sfq_pkg::SFQ_ST_MODE;
                        end
                    end
                sfq_pkg::SFQ_ST_MODE:
                    if (u_e)
                    begin
                        mode_q <= mode_d;
                        cnt_q  <= cnt_q + 6'h01;
                        if (phase_end)
                        begin
                            cnt_q   <= 6'h00;
                            state_q <= sfq_pkg::SFQ_ST_DUMMY;
                        end
                    end
                sfq_pkg::SFQ_ST_DUMMY:
                    if (u_e)
                    begin
                        cnt_q <= cnt_q + 6'h01;
                        if (phase_end)
                        begin
                            cnt_q   <= 6'h00;
                            nib_q   <= 1'b0;
                            bi_q    <= 3'h1;
                            state_q <= sfq_pkg::SFQ_ST_DATA;
                        end
                    end
                sfq_pkg::SFQ_ST_DATA:
                    if (!ddr_q && fall_e)
                    begin
                        nib_q <= ~nib_q;
                        if (nib_q)
                            addr_q <= addr_nx;
                    end
                    else if (ddr_q && (rise_e || fall_e))
                    begin
                        bi_q <= bi_q + 3'h1;
                        if (bi_q == 3'h7)
                            addr_q <= addr_nx;
                    end
                default: state_q <= state_q;
            endcase
        end
    end

    // continuous-mode bookkeeping; decisions take effect when select rises
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rcnt_q      <= 4'h0;
            valid_q     <= 1'b0;
            pend_quad_q <= 1'b0;
            pend_ddr_q  <= 1'b0;
            cont_quad_q <= 1'b0;
            cont_ddr_q  <= 1'b0;
        end
        else if (cs_fall)
        begin
            rcnt_q      <= 4'h0;
            valid_q     <= 1'b0;
            pend_quad_q <= 1'b0;
            pend_ddr_q  <= 1'b0;
        end
        else if (cs_rise)
        begin
            if (rcnt_q <= sfq_pkg::SFQ_SHORT_CLKS && !valid_q)
            begin
                cont_quad_q <= 1'b0;
                cont_ddr_q  <= 1'b0;
            end
            else
            begin
                cont_quad_q <= pend_quad_q;
                cont_ddr_q  <= pend_ddr_q;
            end
        end
        else
        begin
            if (rise_e && rcnt_q != 4'hF)
                rcnt_q <= rcnt_q + 4'h1;
            if (phase_end && state_q == sfq_pkg::SFQ_ST_ADDR)
                valid_q <= 1'b1;
            if (phase_end && state_q == sfq_pkg::SFQ_ST_MODE)
            begin
                // lower quad nibble is don't care
                pend_quad_q <= !ddr_q && mode_d[7:4] == sfq_pkg::SFQ_MODE_CONT;
                pend_ddr_q  <= ddr_q && mode_d[7:4] == ~mode_d[3:0];
            end
        end
    end

    // pin drive; io is never sampled in dummy; quad holds off until data, ddr may drive the learning pattern in dummy
    always_ff @(posedge clk)
    begin
        if (!rstn || cs_s)
        begin
            io_out_q  <= 4'h0;
            io_oe_n_q <= sfq_pkg::SFQ_OE_OFF;
        end
        else if (state_q == sfq_pkg::SFQ_ST_DUMMY && ddr_q && u_e)
        begin
            if (phase_end)
            begin
                io_out_q[1] <= mem_data[7];
                io_oe_n_q   <= sfq_pkg::SFQ_OE_SO;
            end
            else if (data_learning_preamble &&
                     cnt_q + 6'h01 + sfq_pkg::SFQ_DLP_EDGS >= plen_c)
            begin
                // pattern shortened if the dummy phase is four clocks or fewer
                io_out_q[1] <= dlp_pattern[3'(plen_c - cnt_q - 6'h02)];
                io_oe_n_q   <= sfq_pkg::SFQ_OE_SO;
            end
        end
        else if (state_q == sfq_pkg::SFQ_ST_DATA)
        begin
            if (!ddr_q && fall_e)
            begin
                io_out_q  <= nib_q ? mem_data[3:0] : mem_data[7:4];
                io_oe_n_q <= sfq_pkg::SFQ_OE_ALL;
            end
            else if (ddr_q && (rise_e || fall_e))
                io_out_q[1] <= mem_data[~bi_q];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            hold_active_q <= 1'b0;
        else
            hold_active_q <= ~hold_s & ~(ddr_q & ~cs_s &
                             state_q != sfq_pkg::SFQ_ST_OPC);
    end

    assign io_out      = io_out_q;
    assign io_oe_n     = io_oe_n_q;
    assign hold_active = hold_active_q;
    assign mem_addr    = addr_q;
    assign cont_quad   = cont_quad_q;
    assign cont_ddr    = cont_ddr_q;

    default clocking sfq_cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_quad_gate: assert property (state_q == sfq_pkg::SFQ_ST_OPC && !cs_fall
        && phase_end && is_qio && !quad_en
        |=> state_q == sfq_pkg::SFQ_ST_IGN)
        else $error("quad command taken without quad enable");
    a_four_byte: assert property (state_q == sfq_pkg::SFQ_ST_OPC && !cs_fall
        && phase_end && opc_d == sfq_pkg::SFQ_OPC_DDR4 |=> four_q && ddr_q)
        else $error("four byte ddr opcode gave short address");
    a_dummy_quiet: assert property (state_q == sfq_pkg::SFQ_ST_DUMMY && !ddr_q
        |-> io_oe_n == sfq_pkg::SFQ_OE_OFF)
        else $error("quad dummy drove lines");
    a_quad_nibble: assert property (state_q == sfq_pkg::SFQ_ST_DATA && !ddr_q
        && fall_e && !nib_q && !cs_fall
        |=> io_out == $past(mem_data[7:4]) && io_oe_n == 4'h0)
        else $error("quad upper nibble not driven");
    a_addr_incr: assert property (state_q == sfq_pkg::SFQ_ST_DATA && !ddr_q
        && fall_e && nib_q && !cs_fall
        |=> addr_q == $past(addr_nx))
        else $error("address did not step after byte");
    a_ddr_bit: assert property (state_q == sfq_pkg::SFQ_ST_DATA && ddr_q
        && (rise_e || fall_e) && !cs_fall
        |=> io_out[1] == $past(mem_data[~bi_q]))
        else $error("ddr data bit wrong");
    a_mode_commit: assert property (cs_rise && !(rcnt_q <= 4'h8 && !valid_q)
        |=> cont_quad == $past(pend_quad_q) && cont_ddr == $past(pend_ddr_q))
        else $error("continuous mode not taken from mode bits");
    a_short_rel: assert property (cs_rise && rcnt_q <= 4'h8 && !valid_q
        |=> !cont_quad && !cont_ddr)
        else $error("short pulse did not release continuous mode");
    a_hold_off: assert property (ddr_q && !cs_s
        && state_q != sfq_pkg::SFQ_ST_OPC |=> !hold_active)
        else $error("hold active in ddr read");
    a_dlp_drive: assert property (state_q == sfq_pkg::SFQ_ST_DUMMY && ddr_q
        && data_learning_preamble && u_e && !cs_fall
        && cnt_q + 6'h09 == plen_c |=> io_oe_n[1] == 1'b0
        && io_out[1] == $past(dlp_pattern[7]))
        else $error("learning pattern not started four clocks early");

    c_quad_data: cover property (state_q == sfq_pkg::SFQ_ST_DATA && !ddr_q
        && fall_e);
    c_ddr_data: cover property (state_q == sfq_pkg::SFQ_ST_DATA && ddr_q
        && rise_e);
    c_cont_quad: cover property (cs_fall && cont_quad_q);
    c_cont_ddr: cover property (cs_fall && cont_ddr_q);

endmodule : sfq_read_seq

// ---- sfq_read_seq_test.sv ----
// self-checking bench for the quad and double rate read sequencer
// assumes sfq_pkg and sfq_host are compiled before this file
`timescale 1ns/1ps

module sfq_read_seq_test;
    logic        clk, rstn, sck, cs_n, hold_n, hold_active;
    logic [3:0]  io_in, io_out, io_oe_n;
    logic [7:0]  config_reg_one, dlp_pattern, mem_data;
    logic        extended_address_sel, enhanced_latency_table;
    logic        data_learning_preamble, cont_quad, cont_ddr;
    logic [31:0] mem_addr;
    int          failures = 0;
    int          checks = 0;
    localparam logic [7:0]  q_op [4] = '{8'hEB, 8'hEB, 8'hEC, 8'hEC};
    localparam logic [31:0] q_a [4] = '{32'h00123456, 32'hFFFFFFFF,
                                        32'h0000ABCD, 32'h7FFFFFFE};
    localparam logic [7:0]  d_op [3] = '{8'h0D, 8'h0D, 8'h0E};
    localparam logic [31:0] d_a [3] = '{32'h00345678, 32'hFFFFFFFF,
                                        32'h0000FFFF};

    function automatic logic [7:0] mb(input logic [31:0] a);
        return a[7:0] ^ a[31:24] ^ 8'h3C;
    endfunction : mb

    function automatic logic [63:0] xr(input logic [31:0] a, input int n);
        logic [63:0] v;
        v = '0;
        for (int k = 0; k < n; k++)
            v = {v[55:0], mb(a + 32'(k))};
        return v;
    endfunction : xr

    assign mem_data = mb(mem_addr);

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    sfq_read_seq i_sfq_read_seq (.clk, .rstn, .sck, .cs_n, .io_in, .io_out,
        .io_oe_n, .hold_n, .hold_active, .config_reg_one,
        .extended_address_sel, .enhanced_latency_table,
        .data_learning_preamble, .dlp_pattern, .mem_addr, .mem_data,
        .cont_quad, .cont_ddr);
    sfq_host i_sfq_host (.clk, .sck, .cs_n, .io_in, .io_out, .io_oe_n,
        .hold_active);

    task automatic cmp(input string nm, input logic [63:0] got,
        input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp

    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic set_cfg(input logic [1:0] lc, input logic qe,
        input logic ext, input logic enh);
        @(posedge clk);
        config_reg_one <= {lc, 4'h0, qe, 1'b0};
        extended_address_sel <= ext;
        enhanced_latency_table <= enh;
        repeat (2) @(posedge clk);
    endtask : set_cfg

    task automatic chk_ddr(input logic [31:0] a, input logic c);
        cmp("ddr_data", i_sfq_host.rx, xr(a, 2));
        cmp("ddr_cont", cont_ddr, c);
    endtask : chk_ddr

    initial
    begin : wdog
        repeat (80000) @(posedge clk);
        failures++;
        end_sim();
    end

    initial
    begin
        rstn = 1'b0;
        hold_n = 1'b1;
        config_reg_one = 8'h02;
        extended_address_sel = 1'b0;
        enhanced_latency_table = 1'b0;
        data_learning_preamble = 1'b0;
        dlp_pattern = 8'hC5;
        repeat (20) @(negedge clk);
        cmp("reset_out", {io_oe_n, cont_quad, cont_ddr, mem_addr},
            {4'hF, 34'h000000000});
        @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        for (int t = 0; t < 4; t++)
        begin
            set_cfg(2'(t), 1'b1, t[0], t[0]);
            i_sfq_host.quad_read(1'b1, q_op[t], q_a[t], (t == 0) ? 6 : 8,
                8'h5F, sfq_pkg::SFQ_QIO_DUMMY[t], 3);
            cmp("quad_data", i_sfq_host.rx, xr(q_a[t], 3));
            cmp("quad_oe", {i_sfq_host.oe_dum, i_sfq_host.oe_dat}, 8'hF0);
            cmp("quad_cont", cont_quad, 1'b0);
        end
        for (int t = 0; t < 3; t++)
        begin
            set_cfg(t == 1 ? 2'h3 : 2'(t), 1'b1, t == 1, t == 1);
            i_sfq_host.ddr_read(1'b1, d_op[t], d_a[t], (t == 0) ? 24 : 32,
                t == 1, 8'h12, (t == 1) ? sfq_pkg::SFQ_DDR_DUMMY_E[3] :
                sfq_pkg::SFQ_DDR_DUMMY_B[t], 1'b0, 2);
            chk_ddr(d_a[t], 1'b0);
            cmp("ddr_oe", i_sfq_host.oe_dum, 4'hF);
        end
        set_cfg(2'h3, 1'b1, 1'b0, 1'b1);
        data_learning_preamble <= 1'b1;
        hold_n <= 1'b0;
        i_sfq_host.ddr_read(1'b1, 8'h0D, 32'h00ABCDEF, 24, 1'b1, 8'hA5,
            sfq_pkg::SFQ_DDR_DUMMY_E[3], 1'b1, 2);
        chk_ddr(32'h00ABCDEF, 1'b1);
        cmp("pattern", i_sfq_host.pat, 8'hC5);
        cmp("hold_in_ddr", i_sfq_host.hold_seen, 1'b0);
        i_sfq_host.ddr_read(1'b0, 8'h00, 32'h00000010, 24, 1'b1, 8'h0F,
            sfq_pkg::SFQ_DDR_DUMMY_E[3], 1'b1, 2);
        chk_ddr(32'h00000010, 1'b1);
        i_sfq_host.ddr_read(1'b0, 8'h00, 32'h00FFFFFE, 24, 1'b1, 8'h11,
            sfq_pkg::SFQ_DDR_DUMMY_E[3], 1'b1, 2);
        chk_ddr(32'h00FFFFFE, 1'b0);
        cmp("hold_idle", hold_active, 1'b1);
        hold_n <= 1'b1;
        set_cfg(2'h0, 1'b1, 1'b0, 1'b0);
        i_sfq_host.quad_read(1'b1, 8'hEB, 32'h00000100, 6, 8'hA3, 4, 2);
        cmp("quad_cont", cont_quad, 1'b1);
        i_sfq_host.quad_read(1'b0, 8'h00, 32'h00FF00F0, 6, 8'hA0, 4, 2);
        cmp("quad_data", i_sfq_host.rx, xr(32'h00FF00F0, 2));
        cmp("quad_cont", cont_quad, 1'b1);
        i_sfq_host.short_frame();
        cmp("cont_after_short", {cont_quad, cont_ddr}, 2'b00);
        i_sfq_host.quad_read(1'b1, 8'hEB, 32'h00000200, 6, 8'h00, 4, 2);
        cmp("quad_data", i_sfq_host.rx, xr(32'h00000200, 2));
        set_cfg(2'h0, 1'b0, 1'b0, 1'b0);
        i_sfq_host.quad_read(1'b1, 8'hEB, 32'h00000300, 6, 8'hA0, 4, 2);
        cmp("quad_off", {i_sfq_host.oe_dat, cont_quad}, 5'h1E);
        end_sim();
    end
endmodule : sfq_read_seq_test
